// ---- mbw_crc16.sv ----
// Running checksum over received frame bytes
`timescale 1ns/1ns
module mbw_crc16
  import mbw_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  mbw_crc_if.calc c
);
  logic [15:0] crc_q;

  // ------------------------------------------------------------
  // Accumulate; a good frame leaves zero after its check bytes
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || c.clr) begin
      crc_q <= CRC_INIT;
    end else if (c.en) begin
      crc_q <= mbw_crc_step(crc_q, c.data);
    end
  end

  assign c.crc = crc_q;
endmodule

// ---- mbw_if.sv ----
// Carriers between the handler and its checksum and transmit helpers
`timescale 1ns/1ns
interface mbw_crc_if;
  logic clr;
  logic en;
  logic [7:0] data;
  logic [15:0] crc;
  modport user (output clr, output en, output data, input crc);
  modport calc (input clr, input en, input data, output crc);
endinterface

interface mbw_tx_if;
  logic start;
  logic [2:0] len;
  logic [7:0] resp [6];
  logic busy;
  modport src (output start, output len, output resp, input busy);
  modport snk (input start, input len, input resp, output busy);
endinterface

// ---- mbw_master.sv ----
// Serial bus master model: sends queries and takes back the answers
`timescale 1ns/1ns
module mbw_master (
  input wire logic core_clk,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic rx_end,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [7:0] resp[$];
  logic got_last;
  logic slow;

  // Idle levels at time zero
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    rx_end = 1'b0;
    tx_ready = 1'b1;
    got_last = 1'b0;
    slow = 1'b0;
  end

  // Reflected checksum, init ffffh, poly a001h
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // Sends one query; fields come upper byte first from the caller
  // Any sub-function is sent as given; bad flips bit 0 of the checksum low byte
  // Both halves of wide data go in one 10h query
  // Start, count, byte count = 2*count, then values
  task automatic send(input logic [7:0] q[$], input bit bad);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0] ^ {7'h00, bad});
    q.push_back(c[15:8]);
    resp.delete();
    got_last = 1'b0;
    foreach (q[i]) begin
      @(posedge core_clk);
      rx_byte <= q[i];
      rx_valid <= 1'b1;
    end
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_byte <= ~q[q.size()-1]; // Released lane shows no stale byte
    rx_end <= 1'b1;
    @(posedge core_clk);
    rx_end <= 1'b0;
  endtask

  // Takes answer bytes, stalling every other cycle when slow
  always @(posedge core_clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready) begin
      resp.push_back(tx_byte);
      if (tx_last) begin
        got_last <= 1'b1;
      end
    end
  end
endmodule

// ---- mbw_pkg.sv ----
// Constants, frame layout and checksum step for the register write handler
package mbw_pkg;
  // ------------------------------------------------------------
  // Function codes and answers
  // ------------------------------------------------------------
  localparam logic [7:0] FC_WRITE_ONE = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [15:0] SUB_ECHO = 16'h0000;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_BAD_DATA = 8'h8c;
  localparam int MAX_REGS = 16;
  // ------------------------------------------------------------
  // Frame layout (byte positions) and lengths
  // ------------------------------------------------------------
  localparam int POS_SLAVE = 0;
  localparam int POS_FC = 1;
  localparam int POS_A_HI = 2;
  localparam int POS_A_LO = 3;
  localparam int POS_V_HI = 4;
  localparam int POS_V_LO = 5;
  localparam int POS_BYTES = 6;
  localparam int POS_DATA = 7;
  localparam int LEN_SHORT = 8;
  localparam int LEN_MULTI_HDR = 9;
  localparam int MAX_FRAME = LEN_MULTI_HDR + 2 * MAX_REGS;
  localparam int RESP_BYTES = 6;
  localparam logic [2:0] RESP_LEN = 3'h6;
  localparam logic [2:0] EXC_LEN = 3'h3;
  // ------------------------------------------------------------
  // Checksum
  // ------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;

  // One byte into the reflected 16-bit checksum
  function automatic logic [15:0] mbw_crc_step(input logic [15:0] c,
                                               input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction
endpackage

// ---- mbw_top.sv ----
// Register write, diagnosis and multi-write query handler (slave side)
`timescale 1ns/1ns
module mbw_top
  import mbw_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] own_addr,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_end,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready,
  output logic wr_en,
  output logic [15:0] wr_addr,
  output logic [15:0] wr_data,
  input wire logic wr_ok
);
  typedef enum logic [2:0] {
    S_RX, S_CHECK, S_WRITE, S_REPLY, S_WAIT
  } mbw_state_e;

  mbw_state_e state_q;
  logic [7:0] buf_q [MAX_FRAME];
  logic [5:0] cnt_q;
  logic ovf_q;
  logic [15:0] base_q;
  logic [4:0] wcnt_q;
  logic [4:0] widx_q;
  logic [5:0] dpos_q;
  logic wr_en_q;
  logic [15:0] wr_addr_q;
  logic [15:0] wr_data_q;
  logic err_q;
  logic clr_q;
  logic start_q;
  logic [2:0] len_q;
  logic [7:0] resp_q [RESP_BYTES];

  logic frame_ok;
  logic do_one;
  logic do_diag;
  logic do_multi;
  logic bad_multi;
  logic [15:0] rcount;
  logic [15:0] q_addr;
  logic [15:0] q_val;
  logic [5:0] dpos_n;

  mbw_crc_if crc_c ();
  mbw_tx_if tx_c ();

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  mbw_crc16 u_crc (
    .core_clk (core_clk),
    .rst (rst),
    .c (crc_c.calc)
  );

  mbw_tx u_tx (
    .core_clk (core_clk),
    .rst (rst),
    .t (tx_c.snk),
    .tx_byte (tx_byte),
    .tx_valid (tx_valid),
    .tx_last (tx_last),
    .tx_ready (tx_ready)
  );

  // Bytes feed the checksum only while a query is being collected
  assign crc_c.clr = clr_q;
  assign crc_c.en = (state_q == S_RX) && rx_valid && !ovf_q;
  assign crc_c.data = rx_byte;

  assign tx_c.start = start_q;
  assign tx_c.len = len_q;
  assign tx_c.resp = resp_q;

  // ------------------------------------------------------------
  // Query decode, looked at in the check state
  // ------------------------------------------------------------
  assign q_addr = {buf_q[POS_A_HI], buf_q[POS_A_LO]};
  assign q_val = {buf_q[POS_V_HI], buf_q[POS_V_LO]};
  assign rcount = q_val;
  assign dpos_n = dpos_q + 6'h1;

  always_comb begin
    frame_ok = (buf_q[POS_SLAVE] == own_addr) && !ovf_q
               && (crc_c.crc == CRC_GOOD);
    do_one = frame_ok && (buf_q[POS_FC] == FC_WRITE_ONE)
             && (cnt_q == 6'(LEN_SHORT));
    do_diag = frame_ok && (buf_q[POS_FC] == FC_DIAG)
              && (cnt_q == 6'(LEN_SHORT)) && (q_addr == SUB_ECHO);
    do_multi = frame_ok && (buf_q[POS_FC] == FC_WRITE_MULTI)
               && (cnt_q >= 6'(LEN_MULTI_HDR));
    bad_multi = (rcount == 16'h0000) || (rcount > 16'(MAX_REGS))
                || ({8'h00, buf_q[POS_BYTES]} != {rcount[14:0], 1'b0})
                || (cnt_q != 6'(LEN_MULTI_HDR) + buf_q[POS_BYTES][5:0]);
  end

  // ------------------------------------------------------------
  // Receive buffer
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || clr_q) begin
      cnt_q <= 6'h0;
      ovf_q <= 1'b0;
    end else if (state_q == S_RX && rx_valid && !ovf_q) begin
      if (cnt_q == 6'(MAX_FRAME)) begin
        ovf_q <= 1'b1;
      end else begin
        buf_q[cnt_q] <= rx_byte;
        cnt_q <= cnt_q + 6'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Control sequence
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= S_RX;
      clr_q <= 1'b1;
      start_q <= 1'b0;
      base_q <= 16'h0000;
      wcnt_q <= 5'h0;
      widx_q <= 5'h0;
      dpos_q <= 6'h0;
      len_q <= RESP_LEN;
      for (int i = 0; i < RESP_BYTES; i++) begin
        resp_q[i] <= 8'h00;
      end
    end else begin
      clr_q <= 1'b0;
      start_q <= 1'b0;
      unique case (state_q)
        S_RX: begin
          if (rx_end && cnt_q != 6'h0) begin
            state_q <= S_CHECK;
          end
        end
        S_CHECK: begin
          base_q <= q_addr;
          widx_q <= 5'h0;
          if (do_one) begin
            wcnt_q <= 5'h1;
            dpos_q <= 6'(POS_V_HI);
            state_q <= S_WRITE;
          end else if (do_multi && !bad_multi) begin
            wcnt_q <= rcount[4:0];
            dpos_q <= 6'(POS_DATA);
            state_q <= S_WRITE;
          end else if (do_diag) begin
            wcnt_q <= 5'h0;
            state_q <= S_WRITE;
          end else if (do_multi) begin
            wcnt_q <= 5'h0;
            state_q <= S_WRITE;
          end else begin
            clr_q <= 1'b1;
            state_q <= S_RX;
          end
        end
        S_WRITE: begin
          if (widx_q < wcnt_q) begin
            widx_q <= widx_q + 5'h1;
            dpos_q <= dpos_q + 6'h2;
          end else begin
            state_q <= S_REPLY;
          end
        end
        S_REPLY: begin
          for (int i = 0; i < RESP_BYTES; i++) begin
            resp_q[i] <= buf_q[i];
          end
          len_q <= RESP_LEN;
          if (err_q) begin
            resp_q[POS_FC] <= buf_q[POS_FC] | EXC_FLAG;
            resp_q[POS_A_HI] <= EXC_BAD_DATA;
            len_q <= EXC_LEN;
          end
          start_q <= 1'b1;
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (!start_q && !tx_c.busy) begin
            clr_q <= 1'b1;
            state_q <= S_RX;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Register write port, one register per cycle
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_en_q <= 1'b0;
      wr_addr_q <= 16'h0000;
      wr_data_q <= 16'h0000;
    end else if (state_q == S_WRITE && widx_q < wcnt_q) begin
      wr_en_q <= 1'b1;
      wr_addr_q <= base_q + {11'h000, widx_q};
      wr_data_q <= {buf_q[dpos_q], buf_q[dpos_n]};
    end else begin
      wr_en_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Exception flag: bad register count or byte count, or a refused value
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || state_q == S_RX) begin
      err_q <= 1'b0;
    end else if (state_q == S_CHECK && do_multi && bad_multi) begin
      err_q <= 1'b1;
    end else if (wr_en_q && !wr_ok) begin
      err_q <= 1'b1;
    end
  end

  assign wr_en = wr_en_q;
  assign wr_addr = wr_addr_q;
  assign wr_data = wr_data_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence one_write_s;
    state_q == S_CHECK && do_one;
  endsequence

  sequence reply_s;
    state_q == S_REPLY;
  endsequence

  single_write_a: assert property (one_write_s |-> ##2
    (wr_en_q && wr_addr_q == q_addr && wr_data_q == q_val))
    else $error("single write not issued with query address and value");
  single_echo_a: assert property ((reply_s ##0 (!err_q
    && buf_q[POS_FC] == FC_WRITE_ONE)) |=> len_q == RESP_LEN
    && resp_q[POS_A_LO] == buf_q[POS_A_LO]
    && resp_q[POS_V_LO] == buf_q[POS_V_LO])
    else $error("single write answer differs from query");
  diag_echo_a: assert property ((state_q == S_CHECK && do_diag)
    |-> ##3 start_q && len_q == RESP_LEN && resp_q[POS_V_HI] == q_val[15:8])
    else $error("diagnosis answer not echoed");
  write_limit_a: assert property (wr_en_q |-> wcnt_q <= 5'(MAX_REGS))
    else $error("more than sixteen registers written");
  ascend_order_a: assert property ((wr_en_q && $past(wr_en_q))
    |-> wr_addr_q == $past(wr_addr_q) + 16'h0001)
    else $error("multi write not in ascending order");
  multi_short_a: assert property ((reply_s ##0 !err_q
    && buf_q[POS_FC] == FC_WRITE_MULTI) |=> len_q == RESP_LEN)
    else $error("multi write answer has wrong length");
  count_exc_a: assert property ((state_q == S_CHECK && do_multi
    && bad_multi) |-> ##2 reply_s ##1 (len_q == EXC_LEN
    && resp_q[POS_A_HI] == EXC_BAD_DATA && !$past(wr_en_q)))
    else $error("count mismatch did not give exception");
  match_only_a: assert property ((state_q == S_CHECK && !frame_ok)
    |=> state_q == S_RX && !wr_en_q)
    else $error("acted on foreign or corrupt query");
  reply_after_a: assert property ($rose(start_q) |-> !wr_en_q
    && $past(state_q) == S_REPLY)
    else $error("answer started before writes ended");
  // A refused value still ends in an exception answer
  refuse_exc_a: assert property ((wr_en_q && !wr_ok)
    |-> ##[2:17] (start_q && len_q == EXC_LEN))
    else $error("refused write gave no exception answer");
endmodule

// ---- mbw_top_end.sv ----
// Spare file of the handler; it holds no logic of its own

// ---- mbw_top_tb.sv ----
// Self-checking testbench of the register write and diagnosis handler
`timescale 1ns/1ns
module mbw_top_tb;
  import mbw_pkg::*;
  logic core_clk, rst, rx_valid, rx_end, tx_valid, tx_last, tx_ready;
  logic wr_en, wr_ok, first_seen;
  logic [7:0] own_addr, rx_byte, tx_byte;
  logic [15:0] wr_addr, wr_data;
  logic [15:0] wq[$];
  logic [15:0] none16[$];
  logic [7:0] none8[$];
  int wr_at_tx, err_total, checks_done;

  // ------------------------------------------------------------
  // Clock, instances and write responder
  // ------------------------------------------------------------
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  assign wr_ok = (wr_data !== 16'hdead); // Out of range value refused

  mbw_top i_mbw_top (.core_clk(core_clk), .rst(rst), .own_addr(own_addr),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_end(rx_end),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_ok(wr_ok));
  mbw_master i_mbw_master (.core_clk(core_clk), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_end(rx_end), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));

  // Records writes and how many came before the answer started
  always @(posedge core_clk) begin
    if (wr_en === 1'b1) begin
      wq.push_back(wr_addr);
      wq.push_back(wr_data);
    end
    if (tx_valid === 1'b1 && !first_seen) begin
      first_seen = 1'b1;
      wr_at_tx = wq.size();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic cmp16(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One query; er holds the answer without checksum, empty for none
  task automatic run(input logic [7:0] adr, input logic [7:0] q[$],
    input bit bad, input logic [15:0] ew[$], input logic [7:0] er[$]);
    logic [15:0] c;
    int n;
    logic fin;
    @(posedge core_clk);
    own_addr <= adr;
    wq.delete();
    first_seen = 1'b0;
    i_mbw_master.send(q, bad);
    n = 0;
    while (!i_mbw_master.got_last && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    fin = i_mbw_master.got_last;
    cmp16("tx_last seen", {15'h0, er.size() > 0}, {15'h0, fin});
    if (er.size() > 0) begin
      c = i_mbw_master.crc16(er);
      er.push_back(c[7:0]);
      er.push_back(c[15:8]);
      cmp16("writes before answer", 16'(ew.size()), 16'(wr_at_tx));
    end
    cmp16("write count", 16'(ew.size()), 16'(wq.size()));
    foreach (ew[i]) begin
      if (i < wq.size()) cmp16("write", ew[i], wq[i]);
    end
    cmp16("answer length", 16'(er.size()), 16'(i_mbw_master.resp.size()));
    foreach (er[i]) begin
      if (i < i_mbw_master.resp.size()) begin
        cmp16("answer byte", er[i], i_mbw_master.resp[i]);
      end
    end
    repeat (2) @(posedge core_clk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_single();
    run(8'h02, '{8'h02, 8'h06, 8'h02, 8'h4b, 8'h00, 8'h50}, 1'b0,
      '{16'h024b, 16'h0050},
      '{8'h02, 8'h06, 8'h02, 8'h4b, 8'h00, 8'h50});
  endtask

  task automatic t_diag();
    run(8'h03, '{8'h03, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, 1'b0, none16,
      '{8'h03, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34});
    run(8'h03, '{8'h03, 8'h08, 8'h00, 8'h01, 8'h12, 8'h34}, 1'b0, none16,
      none8);
  endtask

  task automatic t_multi();
    logic [7:0] q[$];
    logic [15:0] ew[$];
    i_mbw_master.slow = 1'b1;
    run(8'h04, '{8'h04, 8'h10, 8'h06, 8'h04, 8'h00, 8'h06, 8'h0c,
      8'h00, 8'h00, 8'h27, 8'h10, 8'h00, 8'h00, 8'h4e, 8'h20, 8'h00,
      8'h07, 8'ha1, 8'h20}, 1'b0,
      '{16'h0604, 16'h0000, 16'h0605, 16'h2710, 16'h0606, 16'h0000,
      16'h0607, 16'h4e20, 16'h0608, 16'h0007, 16'h0609, 16'ha120},
      '{8'h04, 8'h10, 8'h06, 8'h04, 8'h00, 8'h06});
    i_mbw_master.slow = 1'b0;
    q = '{8'h05, 8'h10, 8'h00, 8'h10, 8'h00, 8'h10, 8'h20};
    for (int i = 0; i < MAX_REGS; i++) begin
      q.push_back(8'(i));
      q.push_back(8'(i + 1));
      ew.push_back(16'h0010 + 16'(i));
      ew.push_back({8'(i), 8'(i + 1)});
    end
    run(8'h05, q, 1'b0, ew, q[0:5]);
  endtask

  task automatic t_faults();
    run(8'h04, '{8'h04, 8'h10, 8'h00, 8'h30, 8'h00, 8'h02, 8'h04,
      8'hde, 8'had, 8'h00, 8'h05}, 1'b0,
      '{16'h0030, 16'hdead, 16'h0031, 16'h0005},
      '{8'h04, 8'h90, 8'h8c});
    run(8'h04, '{8'h04, 8'h10, 8'h00, 8'h30, 8'h00, 8'h02, 8'h03,
      8'h00, 8'h01, 8'h00}, 1'b0, none16, '{8'h04, 8'h90, 8'h8c});
    run(8'h04, '{8'h04, 8'h10, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00},
      1'b0, none16, '{8'h04, 8'h90, 8'h8c});
    run(8'h05, '{8'h02, 8'h06, 8'h02, 8'h4b, 8'h00, 8'h50}, 1'b0,
      none16, none8);
    run(8'h02, '{8'h02, 8'h06, 8'h02, 8'h4b, 8'h00, 8'h50}, 1'b1,
      none16, none8);
  endtask

  // ------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    own_addr = 8'h00;
    err_total = 0;
    checks_done = 0;
    first_seen = 1'b0;
    wr_at_tx = 0;
    repeat (20) @(posedge core_clk);
    cmp16("tx_valid in reset", 16'h0000, {15'h0000, tx_valid});
    cmp16("wr_en in reset", 16'h0000, {15'h0000, wr_en});
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_single();
    t_diag();
    t_multi();
    t_faults();
    print_verdict();
  end
endmodule

// ---- mbw_tx.sv ----
// Response serialiser appending the checksum, low byte first
`timescale 1ns/1ns
module mbw_tx
  import mbw_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  mbw_tx_if.snk t,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  output logic tx_last,
  input wire logic tx_ready
);
  logic [3:0] idx_q;
  logic [15:0] crc_q;
  logic [7:0] byte_q;
  logic valid_q;
  logic last_q;
  logic busy_q;
  logic [15:0] crc_n;
  logic [3:0] len4;

  assign len4 = {1'b0, t.len};
  // Checksum including the byte just accepted, body bytes only
  assign crc_n = (idx_q <= len4) ? mbw_crc_step(crc_q, byte_q) : crc_q;

  // ------------------------------------------------------------
  // Byte sequencer: body, checksum low, checksum high
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      idx_q <= 4'h0;
      crc_q <= CRC_INIT;
      byte_q <= 8'h00;
      valid_q <= 1'b0;
      last_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (!busy_q && t.start) begin
      idx_q <= 4'h1;
      crc_q <= CRC_INIT;
      byte_q <= t.resp[0];
      valid_q <= 1'b1;
      last_q <= 1'b0;
      busy_q <= 1'b1;
    end else if (valid_q && tx_ready) begin
      crc_q <= crc_n;
      idx_q <= idx_q + 4'h1;
      last_q <= (idx_q == len4 + 4'h1);
      if (idx_q < len4) begin
        byte_q <= t.resp[idx_q[2:0]];
      end else if (idx_q == len4) begin
        byte_q <= crc_n[7:0];
      end else if (idx_q == len4 + 4'h1) begin
        byte_q <= crc_q[15:8];
      end else begin
        valid_q <= 1'b0;
        busy_q <= 1'b0;
      end
    end
  end

  assign tx_byte = byte_q;
  assign tx_valid = valid_q;
  assign tx_last = last_q;
  assign t.busy = busy_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  crc_tail_a: assert property (@(posedge core_clk) disable iff (rst)
    (valid_q && tx_ready && last_q) |=> !valid_q && !busy_q)
    else $error("response did not end after checksum high byte");
endmodule
